// >>> hdl/cctl_pkg.sv
// converter control package: addresses, field positions, reset values,
// start source codes, phase states and bus carrier types
// assumes a byte-wide special-function-register bus with byte and bit writes
package cctl_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] CCTL_CTRL_ADDR = 8'hE8;   // converter_control
  localparam logic [7:0] CCTL_CFG_ADDR  = 8'hBC;   // sar_clock_divider lives here

  // ----------------------------------------------------------------
  // converter_control field positions and reset
  // ----------------------------------------------------------------
  localparam int         CCTL_EN_BIT    = 7;
  localparam int         CCTL_TM_BIT    = 6;
  localparam int         CCTL_DONE_BIT  = 5;
  localparam int         CCTL_BUSY_BIT  = 4;
  localparam int         CCTL_WIN_BIT   = 3;
  localparam logic [7:0] CCTL_CTRL_RST  = 8'h00;

  // configuration register: divider in 7:3, justify select in 2
  localparam int         CCTL_DIV_LSB   = 3;
  localparam int         CCTL_LJST_BIT  = 2;
  localparam logic [4:0] CCTL_DIV_RST   = 5'h1F;

  // ----------------------------------------------------------------
  // start source codes and timing
  // ----------------------------------------------------------------
  localparam logic [2:0] CCTL_SRC_SW    = 3'h0;
  localparam logic [2:0] CCTL_SRC_TMR0  = 3'h1;
  localparam logic [2:0] CCTL_SRC_TMRA  = 3'h2;
  localparam logic [2:0] CCTL_SRC_TMRB  = 3'h3;
  localparam logic [2:0] CCTL_SRC_EXT   = 3'h4;
  localparam logic [2:0] CCTL_SRC_TMRC  = 3'h5;
  localparam int         CCTL_TRACK_TICKS = 3;    // low-power track phase, sar clocks

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CCTL_OFF,
    CCTL_IDLE,
    CCTL_TRACK,
    CCTL_CONV
  } cctl_phase_type;

  typedef struct packed {
    logic [7:0] addr;
    logic       rd;       // read strobe, data one cycle later
    logic       wr;       // byte write strobe
    logic [7:0] wdata;
    logic       bit_wr;   // single bit write strobe
    logic [2:0] bit_idx;
    logic       bit_val;
  } cctl_sfr_req_type;

endpackage : cctl_pkg

// >>> hdl/cctl_adc_ctrl.sv
// converter control and status: control register, start source select,
// sar clock divider, track and convert sequencing, sticky flags
// assumes one clock; start pin is asynchronous, timer pulses are on CLOCK
`timescale 1ns/1ns
`default_nettype none

module cctl_adc_ctrl #(
  parameter int CONV_TICKS = 11             // sar clocks per conversion
) (
  // clock, reset, enable
  input  wire logic                      CLOCK,
  input  wire logic                      SRST,
  input  wire logic                      CE,
  // register bus
  input  wire cctl_pkg::cctl_sfr_req_type SFR_REQ,
  output logic [7:0]                     SFR_RDATA,
  // start sources and compare result
  input  wire logic [3:0]                TIMER_OVF,
  input  wire logic                      EXT_START_PIN,
  input  wire logic                      WINDOW_MATCH,
  // converter status
  output logic                           CONV_ENABLED,
  output logic                           TRACKING,
  output logic                           CONVERTING,
  output logic                           BUSY,
  output logic                           SAR_TICK,
  output logic                           CONV_START,
  output logic                           CONV_DONE
);
  import cctl_pkg::*;

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (CONV_TICKS < 1 || CONV_TICKS > 255) begin : g_bad_conv_ticks
    $error("CONV_TICKS must lie in 1..255");
  end

  localparam logic [7:0] TRACK_LAST = 8'(CCTL_TRACK_TICKS - 1);
  localparam logic [7:0] CONV_LAST  = 8'(CONV_TICKS - 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic           en;
    logic           tm;
    logic           done_f;
    logic           win_f;
    logic [2:0]     src;
    logic [4:0]     div;
    logic           ljst;
    cctl_phase_type phase;
    logic [7:0]     tick_cnt;
    logic [4:0]     div_cnt;
    logic [2:0]     sync;
    logic           pin_lvl;
    logic [7:0]     rdata;
    logic           start_p;
    logic           done_p;
  } cctl_state_type;

  localparam cctl_state_type STATE_RST = '{
    en: CCTL_CTRL_RST[CCTL_EN_BIT], tm: CCTL_CTRL_RST[CCTL_TM_BIT],
    done_f: CCTL_CTRL_RST[CCTL_DONE_BIT], win_f: CCTL_CTRL_RST[CCTL_WIN_BIT],
    src: CCTL_CTRL_RST[2:0], div: CCTL_DIV_RST, ljst: 1'b0, phase: CCTL_OFF,
    tick_cnt: 8'h00, div_cnt: 5'h00, sync: 3'h0, pin_lvl: 1'b0, rdata: 8'h00,
    start_p: 1'b0, done_p: 1'b0};

  cctl_state_type st_r;
  cctl_state_type st_nxt;

  logic       busy;
  logic       ctrl_hit;
  logic       cfg_hit;
  logic       ctl_wr;
  logic       sw_go;
  logic       pin_rise;
  logic       evt;
  logic       tick;
  logic [7:0] ctrl_rd;
  logic [7:0] cfg_rd;
  logic [7:0] wbyte;

  // start event of the selected source
  function automatic logic cctl_evt_sel(input logic [2:0] src, input logic sw,
                                        input logic [3:0] tmr, input logic pin);
    case (src)
      CCTL_SRC_SW:   cctl_evt_sel = sw;
      CCTL_SRC_TMR0: cctl_evt_sel = tmr[0];
      CCTL_SRC_TMRA: cctl_evt_sel = tmr[1];
      CCTL_SRC_TMRB: cctl_evt_sel = tmr[2];
      CCTL_SRC_EXT:  cctl_evt_sel = pin;
      CCTL_SRC_TMRC: cctl_evt_sel = tmr[3];
      default:       cctl_evt_sel = 1'b0;    // reserved codes start nothing
    endcase
  endfunction : cctl_evt_sel

  // ----------------------------------------------------------------
  // decode and readback
  // ----------------------------------------------------------------
  assign busy     = (st_r.phase == CCTL_TRACK) || (st_r.phase == CCTL_CONV);
  assign ctrl_hit = (SFR_REQ.addr == CCTL_CTRL_ADDR);
  assign cfg_hit  = (SFR_REQ.addr == CCTL_CFG_ADDR);
  assign ctl_wr   = ctrl_hit && (SFR_REQ.wr || SFR_REQ.bit_wr);
  assign ctrl_rd  = {st_r.en, st_r.tm, st_r.done_f, busy, st_r.win_f, st_r.src};
  assign cfg_rd   = {st_r.div, st_r.ljst, 2'b00};
  assign tick     = busy && (st_r.div_cnt == 5'h00);
  // a stable low-to-high change once the second and third stages agree
  assign pin_rise = (st_r.sync[1] == st_r.sync[2]) && st_r.sync[2] && !st_r.pin_lvl;

  // bit writes modify one bit of the current value
  always_comb begin
    wbyte = ctrl_rd;
    if (SFR_REQ.wr) begin
      wbyte = SFR_REQ.wdata;
    end else begin
      wbyte[SFR_REQ.bit_idx] = SFR_REQ.bit_val;
    end
  end

  // busy written to one requests a software start; zero does nothing
  assign sw_go = ctl_wr && (SFR_REQ.wr ? SFR_REQ.wdata[CCTL_BUSY_BIT]
                 : (SFR_REQ.bit_idx == 3'(CCTL_BUSY_BIT)) && SFR_REQ.bit_val);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt         = st_r;
    st_nxt.start_p = 1'b0;
    st_nxt.done_p  = 1'b0;
    evt            = 1'b0;
    // start pin synchroniser and filtered level
    st_nxt.sync = {st_r.sync[1:0], EXT_START_PIN};
    if (st_r.sync[1] == st_r.sync[2]) begin
      st_nxt.pin_lvl = st_r.sync[2];
    end
    // software writes first, so hardware sets below win
    if (ctl_wr) begin
      st_nxt.en     = wbyte[CCTL_EN_BIT];
      st_nxt.tm     = wbyte[CCTL_TM_BIT];
      st_nxt.done_f = wbyte[CCTL_DONE_BIT];
      st_nxt.win_f  = wbyte[CCTL_WIN_BIT];
      st_nxt.src    = wbyte[2:0];
    end
    if (cfg_hit && SFR_REQ.wr) begin
      st_nxt.div  = SFR_REQ.wdata[7:CCTL_DIV_LSB];
      st_nxt.ljst = SFR_REQ.wdata[CCTL_LJST_BIT];
    end
    // sar clock: one tick per div+1 system clocks while busy
    if (busy) begin
      st_nxt.div_cnt = tick ? st_r.div : st_r.div_cnt - 5'h01;
    end
    // start only counts when enabled before and after the write
    evt = st_r.en && st_nxt.en &&
          cctl_evt_sel(st_nxt.src, sw_go, TIMER_OVF, pin_rise);
    case (st_r.phase)
      CCTL_OFF: begin
        if (st_nxt.en) begin
          st_nxt.phase = CCTL_IDLE;
        end
      end
      CCTL_IDLE: begin
        if (evt) begin
          st_nxt.start_p  = 1'b1;
          st_nxt.tick_cnt = 8'h00;
          st_nxt.div_cnt  = st_nxt.div;
          if (st_nxt.tm && st_nxt.src != CCTL_SRC_EXT) begin
            st_nxt.phase = CCTL_TRACK;
          end else begin
            st_nxt.phase = CCTL_CONV;
          end
        end
      end
      CCTL_TRACK: begin
        if (tick) begin
          if (st_r.tick_cnt == TRACK_LAST) begin
            st_nxt.phase    = CCTL_CONV;
            st_nxt.tick_cnt = 8'h00;
          end else begin
            st_nxt.tick_cnt = st_r.tick_cnt + 8'h01;
          end
        end
      end
      CCTL_CONV: begin
        if (tick) begin
          if (st_r.tick_cnt == CONV_LAST) begin
            st_nxt.phase  = CCTL_IDLE;
            st_nxt.done_p = 1'b1;
            st_nxt.done_f = 1'b1;
          end else begin
            st_nxt.tick_cnt = st_r.tick_cnt + 8'h01;
          end
        end
      end
      default: st_nxt.phase = CCTL_OFF;
    endcase
    // disabling aborts any conversion and shuts the converter down
    if (!st_nxt.en) begin
      st_nxt.phase = CCTL_OFF;
    end
    // window match sets its flag over a same-cycle clear
    if (WINDOW_MATCH && st_r.en) begin
      st_nxt.win_f = 1'b1;
    end
    // registered read data, zero for other addresses
    if (SFR_REQ.rd) begin
      st_nxt.rdata = ctrl_hit ? ctrl_rd : (cfg_hit ? cfg_rd : 8'h00);
    end
  end

  // state register, frozen while CE is low
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      st_r <= STATE_RST;
    end else if (CE) begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign SFR_RDATA    = st_r.rdata;
  assign CONV_ENABLED = st_r.en;
  assign CONVERTING   = (st_r.phase == CCTL_CONV);
  assign BUSY         = busy;
  assign SAR_TICK     = tick;
  assign CONV_START   = st_r.start_p;
  assign CONV_DONE    = st_r.done_p;
  // tracking per mode: normal always idle, low-power external while pin low
  assign TRACKING = (st_r.phase == CCTL_TRACK) ||
                    ((st_r.phase == CCTL_IDLE) &&
                     (!st_r.tm || (st_r.src == CCTL_SRC_EXT && !st_r.pin_lvl)));

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);

  sequence s_idle_start;
    CE && st_r.phase == CCTL_IDLE && st_nxt.start_p;
  endsequence

  sequence s_lp_ext_rise;
    CE && st_r.phase == CCTL_IDLE && st_nxt.en && st_nxt.tm &&
    st_nxt.src == CCTL_SRC_EXT && evt;
  endsequence

  chk_off_disabled: assert property ((CE && !st_nxt.en) |=> st_r.phase == CCTL_OFF && !BUSY)
    else $error("converter not shut down while disabled");
  chk_normal_direct: assert property ((s_idle_start and !st_nxt.tm) |=> CONVERTING)
    else $error("normal mode did not convert at once");
  chk_ext_track_low: assert property ((st_r.tm && st_r.src == CCTL_SRC_EXT &&
      st_r.phase == CCTL_IDLE) |-> (TRACKING == !st_r.pin_lvl))
    else $error("external low-power tracking not following pin");
  chk_ext_rise_conv: assert property (s_lp_ext_rise |=> CONVERTING ##0 CONV_START)
    else $error("pin rise did not begin conversion");
  chk_lp_track_len: assert property ((CE && st_r.phase == CCTL_TRACK && st_nxt.phase == CCTL_CONV)
      |-> tick && st_r.tick_cnt == TRACK_LAST)
    else $error("low-power track phase length wrong");
  chk_done_sticky: assert property ((st_r.done_f && !ctl_wr) |=> st_r.done_f)
    else $error("done flag dropped without software");
  chk_done_set: assert property ((CE && st_r.phase == CCTL_CONV && tick &&
      st_r.tick_cnt == CONV_LAST) |=> st_r.done_f && CONV_DONE && !BUSY)
    else $error("done flag not set at conversion end");
  chk_busy_read: assert property ((CE && SFR_REQ.rd && ctrl_hit) |=>
      SFR_RDATA[CCTL_BUSY_BIT] == $past(busy))
    else $error("busy readback wrong");
  chk_sw_start: assert property ((CE && st_r.phase == CCTL_IDLE && st_r.en && st_nxt.en &&
      sw_go && st_nxt.src == CCTL_SRC_SW) |=> BUSY)
    else $error("software start ignored");
  chk_win_set: assert property ((CE && WINDOW_MATCH && st_r.en) |=> st_r.win_f)
    else $error("window flag not set on match");
  chk_ignore_off: assert property ((CE && !st_r.en) |=> !CONV_START)
    else $error("start accepted while disabled");

endmodule : cctl_adc_ctrl

`default_nettype wire

// >>> dv/cctl_start_src.sv
// partner model: timer overflow pulses and the external start pin
// assumes the bench requests pulses and pin levels on the rising edge
`timescale 1ns/1ns
`default_nettype none
module cctl_start_src (
  // clock
  input  wire logic       clock,
  // requests from the bench
  input  wire logic [3:0] fire,
  input  wire logic       pin_lvl,
  // start events toward the block
  output logic [3:0]      timer_ovf,
  output logic            ext_pin
);
  // one-cycle overflow pulses, pin follows the requested level
  always @(posedge clock) begin
    timer_ovf <= fire;
    ext_pin   <= pin_lvl;
  end
endmodule : cctl_start_src
`default_nettype wire

// >>> dv/cctl_adc_ctrl_test.sv
// testbench for the converter control block
// assumes cctl_pkg, cctl_adc_ctrl and cctl_start_src are compiled first
`timescale 1ns/1ns
`default_nettype none
module cctl_adc_ctrl_test;
  import cctl_pkg::*;
  logic             clk, srst, ce, wm, pin_lvl, ext_pin;
  logic [3:0]       fire, tmr;
  cctl_sfr_req_type req;
  logic [7:0]       rdata, d;
  logic             en, trk, conv, busy, tick, start, done;
  logic [2:0]       codes [4] = '{3'h1, 3'h2, 3'h3, 3'h5};
  int               n_mismatch = 0, checked = 0, cycles = 0, n_tick = 0, cyc;

  // ----------------------------------------------------------------
  // design and partner
  // ----------------------------------------------------------------
  cctl_adc_ctrl #(.CONV_TICKS(4)) uut (.CLOCK(clk), .SRST(srst), .CE(ce),
    .SFR_REQ(req), .SFR_RDATA(rdata), .TIMER_OVF(tmr), .EXT_START_PIN(ext_pin),
    .WINDOW_MATCH(wm), .CONV_ENABLED(en), .TRACKING(trk), .CONVERTING(conv),
    .BUSY(busy), .SAR_TICK(tick), .CONV_START(start), .CONV_DONE(done));
  cctl_start_src src (.clock(clk), .fire(fire), .pin_lvl(pin_lvl), .timer_ovf(tmr),
    .ext_pin(ext_pin));

  // ----------------------------------------------------------------
  // clock, tick counter, hang guard
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (tick === 1'b1) n_tick++;
    if (cycles == 2000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    req.addr  <= a;
    req.wdata <= v;
    req.wr    <= 1'b1;
    @(posedge clk);
    req.wr    <= 1'b0;
  endtask : sfr_wr
  task automatic sfr_bit(input logic [2:0] idx, input logic val);
    @(posedge clk);
    req.addr    <= CCTL_CTRL_ADDR;
    req.bit_idx <= idx;
    req.bit_val <= val;
    req.bit_wr  <= 1'b1;
    @(posedge clk);
    req.bit_wr  <= 1'b0;
  endtask : sfr_bit
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk);
    req.rd   <= 1'b0;
    #1 v = rdata;
  endtask : sfr_rd
  // waits for start (0), done (1), converting (2) or a sar tick (3)
  function automatic logic pick(input int sel);
    case (sel)
      0: return start;
      1: return done;
      2: return conv;
      default: return tick;
    endcase
  endfunction : pick
  task automatic wait_for(input int sel, input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (pick(sel) !== 1'b1 && n < lim);
  endtask : wait_for
  task automatic pulse_tmr(input logic [3:0] m);
    @(posedge clk);
    fire <= m;
    @(posedge clk);
    fire <= 4'h0;
  endtask : pulse_tmr
  task automatic stop_test();
    if (n_mismatch == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    srst = 1'b1;
    req = '0;
    fire = 4'h0;
    pin_lvl = 1'b0;
    wm = 1'b0;
    ce = 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    sfr_rd(CCTL_CTRL_ADDR, d); check(d, CCTL_CTRL_RST);
    sfr_rd(CCTL_CFG_ADDR, d); check(d, 8'hF8);
    sfr_rd(8'h55, d); check(d, 8'h00);
    // disabled: a software start is dropped
    sfr_wr(CCTL_CTRL_ADDR, 8'h10);
    wait_for(0, 12, cyc); check(cyc[7:0], 8'd12);
    check(en, 1'b0);
    check(trk, 1'b0);
    // divider 1, enable in normal track mode
    sfr_wr(CCTL_CFG_ADDR, 8'h08);
    sfr_wr(CCTL_CTRL_ADDR, 8'h80);
    sfr_rd(CCTL_CTRL_ADDR, d); check(d, 8'h80);
    check(en, 1'b1);
    check(trk, 1'b1);
    // software start converts at once
    sfr_wr(CCTL_CTRL_ADDR, 8'h90);
    // the start pulse stands in the cycle right after the write edge
    #1 check(start, 1'b1);
    check(busy, 1'b1);
    check(conv, 1'b1);
    check(trk, 1'b0);
    sfr_rd(CCTL_CTRL_ADDR, d); check(d, 8'h90);
    wait_for(3, 8, cyc);
    wait_for(3, 8, cyc); check(cyc[7:0], 8'd2);
    wait_for(1, 30, cyc); check(done, 1'b1);
    check(busy, 1'b0);
    sfr_rd(CCTL_CTRL_ADDR, d); check(d, 8'hA0);
    repeat (20) @(posedge clk);
    sfr_rd(CCTL_CTRL_ADDR, d); check(d, 8'hA0);
    // busy write with a timer source selected does nothing
    sfr_bit(3'd5, 1'b0);
    sfr_wr(CCTL_CTRL_ADDR, 8'h91);
    wait_for(0, 12, cyc); check(cyc[7:0], 8'd12);
    sfr_rd(CCTL_CTRL_ADDR, d); check(d, 8'h81);
    // window flag is sticky until cleared by a bit write
    @(posedge clk) wm <= 1'b1;
    @(posedge clk) wm <= 1'b0;
    repeat (5) @(posedge clk);
    sfr_rd(CCTL_CTRL_ADDR, d); check(d, 8'h89);
    sfr_bit(3'd3, 1'b0);
    sfr_rd(CCTL_CTRL_ADDR, d); check(d, 8'h81);
    // low-power mode, every timer source: three ticks of tracking first
    for (int i = 0; i < 4; i++) begin
      sfr_wr(CCTL_CTRL_ADDR, {5'b10000, codes[i]});
      sfr_bit(3'd6, 1'b1);
      sfr_rd(CCTL_CTRL_ADDR, d); check(d, {5'b11000, codes[i]});
      check(trk, 1'b0);
      pulse_tmr(4'h1 << i);
      wait_for(0, 6, cyc); check(start, 1'b1);
      n_tick = 0;
      check(trk, 1'b1);
      check(conv, 1'b0);
      wait_for(2, 20, cyc); check(n_tick[7:0], 8'd3);
      wait_for(1, 30, cyc); check(done, 1'b1);
      sfr_bit(3'd5, 1'b0);
    end
    // reserved code: no timer starts a conversion
    sfr_wr(CCTL_CTRL_ADDR, 8'hC6);
    pulse_tmr(4'hF);
    wait_for(0, 12, cyc); check(cyc[7:0], 8'd12);
    // external pin: track while low, convert on the rise
    sfr_wr(CCTL_CTRL_ADDR, 8'hC4);
    repeat (4) @(posedge clk);
    #1 check(trk, 1'b1);
    @(posedge clk) pin_lvl <= 1'b1;
    wait_for(0, 10, cyc); check(start, 1'b1);
    check(conv, 1'b1);
    check(trk, 1'b0);
    wait_for(1, 30, cyc); check(done, 1'b1);
    @(posedge clk) pin_lvl <= 1'b0;
    // clock enable low: a write is ignored and all state holds
    ce <= 1'b0;
    sfr_bit(3'd7, 1'b0);
    ce <= 1'b1;
    #1 check(en, 1'b1);
    // disable by a bit write: shutdown, flags and other fields kept
    sfr_bit(3'd7, 1'b0);
    sfr_rd(CCTL_CTRL_ADDR, d); check(d, 8'h64);
    check(en, 1'b0);
    check(trk, 1'b0);
    stop_test();
  end
endmodule : cctl_adc_ctrl_test
`default_nettype wire
